// >>> design/cpu_status_pkg.sv
// package: status word layout, window mapping and timing constants
package cpu_status_pkg;
    // status word field positions
    localparam int HALF_CARRY_BIT  = 8;
    localparam int PRIORITY_HI     = 7;
    localparam int PRIORITY_LO     = 5;
    localparam int LOOP_BUSY_BIT   = 4;
    localparam int NEGATIVE_BIT    = 3;
    localparam int SIGNED_WRAP_BIT = 2;
    localparam int ZERO_BIT        = 1;
    localparam int CARRY_BIT       = 0;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // core control and interrupt control bit positions
    localparam int WINDOW_ENABLE_BIT = 2;
    localparam int PRIORITY_TOP_BIT  = 3;
    localparam int NESTING_DIS_BIT   = 15;
    // register indices on the plain port
    localparam logic [1:0] ADDR_STATUS  = 2'h0;
    localparam logic [1:0] ADDR_CONTROL = 2'h1;
    localparam logic [1:0] ADDR_PAGE    = 2'h2;
    localparam logic [1:0] ADDR_INTCTL  = 2'h3;
    // byte and word carry taps
    localparam int BYTE_NIBBLE_TAP = 4;
    localparam int WORD_BYTE_TAP   = 8;
    // extra cycles for window reads and window address widths
    localparam logic [1:0] EXTRA_NONE  = 2'h0;
    localparam logic [1:0] EXTRA_MOVE  = 2'h1;
    localparam logic [1:0] EXTRA_OTHER = 2'h2;
    localparam int WINDOW_LOW_BITS = 15;
    localparam int PAGE_WIDTH      = 8;
endpackage

// >>> design/cpu_status_and_psv_mapping.sv
// cpu status word with flag update and program window mapping
//
// Summary of operation
// - half carry from bit 4 byte, 8 word
// - bits 7..5 hold priority level 0..7
// - control bit 3 extends priority to 8..15
// - nesting disable makes priority bits read-only
// - bit 4 shows repeat loop active
// - bit 3 set on negative result
// - bit 2 set on signed overflow
// - bit 1 zero, set on zero result, cleared by nonzero
// - bit 0 set on carry out of msb
// - bits 15..9 read as zero
// - redirect when address msb and enable set
// - program address is page plus low 15 bits
// - upper half maps to one of 256 pages
// - program address bit 15 from page bit 0
// - return low 16 bits of program word
// - redirected read lengthens the instruction
// - no redirection during table operations
// - moves add one cycle, others add two
// - in loops add two only at edges
`timescale 1ns/10ps
module cpu_status_and_psv_mapping
    import cpu_status_pkg::*;
#(
    parameter int DATA_WIDTH = 16
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    // register port
    input  wire logic [1:0]            reg_addr,
    input  wire logic [15:0]           reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [15:0]           reg_rdata,
    // alu result and flag update enables
    input  wire logic                  alu_valid,
    input  wire logic                  alu_byte,
    input  wire logic [DATA_WIDTH-1:0] alu_a,
    input  wire logic [DATA_WIDTH-1:0] alu_b,
    input  wire logic                  alu_carry_in,
    input  wire logic                  alu_update_half,
    input  wire logic                  alu_update_neg,
    input  wire logic                  alu_update_wrap,
    input  wire logic                  alu_update_zero,
    input  wire logic                  alu_update_carry,
    input  wire logic                  loop_active,
    // data read request from the datapath
    input  wire logic                  rd_req,
    input  wire logic [15:0]           effective_address,
    input  wire logic                  table_busy,
    input  wire logic                  insn_is_move,
    input  wire logic                  loop_edge,
    input  wire logic [23:0]           prog_word,
    // outputs
    output logic [3:0]                 cpu_priority_level,
    output logic                       user_irq_blocked,
    output logic                       prog_rd,
    output logic [22:0]                prog_addr,
    output logic [15:0]                window_data,
    output logic                       window_hit,
    output logic [1:0]                 extra_cycles,
    output logic                       window_fetch_second
);

    // ==========================================================
    // registers
    logic                  half_carry_flag;
    logic [2:0]            priority_bits;
    logic                  loop_busy_flag;
    logic                  negative_flag;
    logic                  signed_wrap_flag;
    logic                  zero_flag;
    logic                  carry_flag;
    logic [15:0]           core_control_reg;
    logic [15:0]           interrupt_control_one;
    logic [PAGE_WIDTH-1:0] program_window_page;
    logic                  program_window_enable;
    logic                  nesting_disable;

    assign program_window_enable = core_control_reg[WINDOW_ENABLE_BIT];
    assign nesting_disable       = interrupt_control_one[NESTING_DIS_BIT];

    // ==========================================================
    // alu flag computation
    logic [DATA_WIDTH:0]   sum;
    logic [4:0]            nib_sum;
    logic [8:0]            byte_sum;
    logic [7:0]            low_byte_sum;
    logic                  next_half;
    logic                  next_neg;
    logic                  next_wrap;
    logic                  next_zero_result;
    logic                  next_carry;
    logic                  sign_a;
    logic                  sign_b;
    logic                  sign_r;

    always_comb begin
        sum      = {1'b0, alu_a} + {1'b0, alu_b} + {{DATA_WIDTH{1'b0}}, alu_carry_in};
        nib_sum  = {1'b0, alu_a[BYTE_NIBBLE_TAP-1:0]} + {1'b0, alu_b[BYTE_NIBBLE_TAP-1:0]}
                   + {4'h0, alu_carry_in};
        byte_sum = {1'b0, alu_a[WORD_BYTE_TAP-1:0]} + {1'b0, alu_b[WORD_BYTE_TAP-1:0]}
                   + {8'h00, alu_carry_in};
        low_byte_sum = byte_sum[7:0];
        next_half = alu_byte ? nib_sum[BYTE_NIBBLE_TAP] : byte_sum[WORD_BYTE_TAP];
        if (alu_byte) begin
            sign_a     = alu_a[WORD_BYTE_TAP-1];
            sign_b     = alu_b[WORD_BYTE_TAP-1];
            sign_r     = low_byte_sum[WORD_BYTE_TAP-1];
            next_carry = byte_sum[WORD_BYTE_TAP];
            next_zero_result = (low_byte_sum == 8'h00);
        end else begin
            sign_a     = alu_a[DATA_WIDTH-1];
            sign_b     = alu_b[DATA_WIDTH-1];
            sign_r     = sum[DATA_WIDTH-1];
            next_carry = sum[DATA_WIDTH];
            next_zero_result = (sum[DATA_WIDTH-1:0] == '0);
        end
        next_neg  = sign_r;
        next_wrap = (sign_a == sign_b) && (sign_r != sign_a);
    end

    // ==========================================================
    // status flags
    always_ff @(posedge clk) begin
        if (rst) begin
            half_carry_flag  <= STATUS_RESET[HALF_CARRY_BIT];
            negative_flag    <= STATUS_RESET[NEGATIVE_BIT];
            signed_wrap_flag <= STATUS_RESET[SIGNED_WRAP_BIT];
            zero_flag        <= STATUS_RESET[ZERO_BIT];
            carry_flag       <= STATUS_RESET[CARRY_BIT];
        end else if (alu_valid) begin
            // only enabled flags move
            if (alu_update_half)  half_carry_flag  <= next_half;
            if (alu_update_neg)   negative_flag    <= next_neg;
            if (alu_update_wrap)  signed_wrap_flag <= next_wrap;
            if (alu_update_zero && !next_zero_result) zero_flag <= 1'b0;
            if (alu_update_zero && next_zero_result)  zero_flag <= 1'b1;
            if (alu_update_carry) carry_flag       <= next_carry;
        end else if (reg_write && reg_addr == ADDR_STATUS) begin
            half_carry_flag  <= reg_wdata[HALF_CARRY_BIT];
            negative_flag    <= reg_wdata[NEGATIVE_BIT];
            signed_wrap_flag <= reg_wdata[SIGNED_WRAP_BIT];
            zero_flag        <= reg_wdata[ZERO_BIT];
            carry_flag       <= reg_wdata[CARRY_BIT];
        end
    end

    // priority bits, locked when nesting disabled
    always_ff @(posedge clk) begin
        if (rst) begin
            priority_bits <= STATUS_RESET[PRIORITY_HI:PRIORITY_LO];
        end else if (reg_write && reg_addr == ADDR_STATUS && !nesting_disable) begin
            priority_bits <= reg_wdata[PRIORITY_HI:PRIORITY_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            loop_busy_flag <= STATUS_RESET[LOOP_BUSY_BIT];
        end else begin
            loop_busy_flag <= loop_active;
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            core_control_reg      <= 16'h0000;
            interrupt_control_one <= 16'h0000;
            program_window_page   <= '0;
        end else if (reg_write) begin
            case (reg_addr)
                ADDR_CONTROL: core_control_reg      <= reg_wdata;
                ADDR_PAGE:    program_window_page   <= reg_wdata[PAGE_WIDTH-1:0];
                ADDR_INTCTL:  interrupt_control_one <= reg_wdata;
                default:      ;
            endcase
        end
    end

    // ==========================================================
    // register read
    logic [15:0] status_word;
    always_comb begin
        status_word                              = 16'h0000;
        status_word[HALF_CARRY_BIT]              = half_carry_flag;
        status_word[PRIORITY_HI:PRIORITY_LO]     = priority_bits;
        status_word[LOOP_BUSY_BIT]               = loop_busy_flag;
        status_word[NEGATIVE_BIT]                = negative_flag;
        status_word[SIGNED_WRAP_BIT]             = signed_wrap_flag;
        status_word[ZERO_BIT]                    = zero_flag;
        status_word[CARRY_BIT]                   = carry_flag;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_STATUS:  reg_rdata <= status_word;
                ADDR_CONTROL: reg_rdata <= core_control_reg;
                ADDR_PAGE:    reg_rdata <= {{(16-PAGE_WIDTH){1'b0}}, program_window_page};
                ADDR_INTCTL:  reg_rdata <= interrupt_control_one;
                default:      reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ==========================================================
    // priority outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_priority_level <= 4'h0;
            user_irq_blocked   <= 1'b0;
        end else begin
            cpu_priority_level <= {core_control_reg[PRIORITY_TOP_BIT], priority_bits};
            user_irq_blocked   <= core_control_reg[PRIORITY_TOP_BIT] || (&priority_bits);
        end
    end

    // ==========================================================
    // program window mapping
    typedef enum {IDLE, FIRST, SECOND} window_state_type;
    window_state_type state;
    logic             hit;
    assign hit = rd_req && effective_address[WINDOW_LOW_BITS] && program_window_enable && !table_busy;

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= IDLE;
        end else begin
            case (state)
                IDLE:    if (hit) state <= FIRST;
                FIRST:   state <= SECOND;
                SECOND:  state <= IDLE;
                default: state <= IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prog_rd             <= 1'b0;
            prog_addr           <= 23'h000000;
            window_hit          <= 1'b0;
            extra_cycles        <= EXTRA_NONE;
            window_fetch_second <= 1'b0;
        end else begin
            prog_rd             <= hit && state == IDLE;
            window_hit          <= hit && state == IDLE;
            window_fetch_second <= state == FIRST;
            if (hit && state == IDLE) begin
                // page on top of low 15 address bits; ea bit 15 dropped
                prog_addr <= {program_window_page, effective_address[WINDOW_LOW_BITS-1:0]};
                if (loop_active) begin
                    extra_cycles <= loop_edge ? EXTRA_OTHER : EXTRA_NONE;
                end else begin
                    extra_cycles <= insn_is_move ? EXTRA_MOVE : EXTRA_OTHER;
                end
            end else if (state == IDLE) begin
                extra_cycles <= EXTRA_NONE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            window_data <= 16'h0000;
        end else if (state == SECOND) begin
            // memory answers one cycle after the fetch strobe
            window_data <= prog_word[15:0];
        end
    end

    // ==========================================================
    // checks: program window
    sequence s_hit;
        hit && state == IDLE;
    endsequence

    sequence s_fetch;
        ##1 prog_rd ##1 window_fetch_second;
    endsequence

    sequence s_second;
        state == SECOND;
    endsequence

    redirect_fetch_a: assert property (@(posedge clk) disable iff (rst) s_hit |-> s_fetch)
        else $error("window read did not take two fetches");
    page_concat_a: assert property (@(posedge clk) disable iff (rst)
        s_hit |=> prog_addr[WINDOW_LOW_BITS] == $past(program_window_page[0]))
        else $error("program address bit 15 not from page");
    page_top_a: assert property (@(posedge clk) disable iff (rst)
        s_hit |=> prog_addr[WINDOW_LOW_BITS+PAGE_WIDTH-1:WINDOW_LOW_BITS] == $past(program_window_page))
        else $error("program address page field wrong");
    low_bits_a: assert property (@(posedge clk) disable iff (rst)
        s_hit |=> prog_addr[WINDOW_LOW_BITS-1:0] == $past(effective_address[WINDOW_LOW_BITS-1:0]))
        else $error("program address low bits wrong");
    no_table_a: assert property (@(posedge clk) disable iff (rst)
        table_busy && state == IDLE |=> !prog_rd)
        else $error("window active during table operation");
    no_enable_a: assert property (@(posedge clk) disable iff (rst)
        !program_window_enable |=> !prog_rd)
        else $error("window fetch while disabled");
    low_half_a: assert property (@(posedge clk) disable iff (rst)
        !(rd_req && effective_address[WINDOW_LOW_BITS]) |=> !prog_rd)
        else $error("window fetch for lower data half");
    busy_refuse_a: assert property (@(posedge clk) disable iff (rst)
        state != IDLE |=> !prog_rd)
        else $error("window fetch started while busy");
    window_data_a: assert property (@(posedge clk) disable iff (rst)
        s_second |=> window_data == $past(prog_word[15:0]))
        else $error("window data not low program word");
    move_extra_a: assert property (@(posedge clk) disable iff (rst)
        (s_hit and (!loop_active && insn_is_move)) |=> extra_cycles == EXTRA_MOVE)
        else $error("move extra cycles wrong");
    other_extra_a: assert property (@(posedge clk) disable iff (rst)
        (s_hit and (!loop_active && !insn_is_move)) |=> extra_cycles == EXTRA_OTHER)
        else $error("other extra cycles wrong");
    loop_extra_a: assert property (@(posedge clk) disable iff (rst)
        (s_hit and (loop_active && !loop_edge)) |=> extra_cycles == EXTRA_NONE)
        else $error("loop iteration extra cycles wrong");
    edge_extra_a: assert property (@(posedge clk) disable iff (rst)
        (s_hit and (loop_active && loop_edge)) |=> extra_cycles == EXTRA_OTHER)
        else $error("loop edge extra cycles wrong");

    // ==========================================================
    // checks: status word
    priority_lock_a: assert property (@(posedge clk) disable iff (rst)
        nesting_disable |=> $stable(priority_bits))
        else $error("priority changed while locked");
    priority_write_a: assert property (@(posedge clk) disable iff (rst)
        reg_write && reg_addr == ADDR_STATUS && !nesting_disable
        |=> priority_bits == $past(reg_wdata[PRIORITY_HI:PRIORITY_LO]))
        else $error("priority write not taken");
    upper_zero_a: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == ADDR_STATUS |=> reg_rdata[15:9] == 7'h00)
        else $error("unimplemented status bits nonzero");
    zero_sticky_a: assert property (@(posedge clk) disable iff (rst)
        alu_valid && alu_update_zero && !next_zero_result |=> !zero_flag)
        else $error("zero flag not cleared on nonzero");
    zero_set_a: assert property (@(posedge clk) disable iff (rst)
        alu_valid && alu_update_zero && next_zero_result |=> zero_flag)
        else $error("zero flag not set on zero");
    zero_hold_a: assert property (@(posedge clk) disable iff (rst)
        !alu_valid && !(reg_write && reg_addr == ADDR_STATUS) |=> $stable(zero_flag))
        else $error("zero flag moved without an update");
    flag_hold_a: assert property (@(posedge clk) disable iff (rst)
        alu_valid && !alu_update_carry |=> $stable(carry_flag))
        else $error("carry changed on non affecting op");
    wrap_hold_a: assert property (@(posedge clk) disable iff (rst)
        alu_valid && !alu_update_wrap |=> $stable(signed_wrap_flag))
        else $error("overflow changed on non affecting op");
    half_hold_a: assert property (@(posedge clk) disable iff (rst)
        alu_valid && !alu_update_half |=> $stable(half_carry_flag))
        else $error("half carry changed on non affecting op");
    level_out_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> cpu_priority_level == {$past(core_control_reg[PRIORITY_TOP_BIT]), $past(priority_bits)})
        else $error("effective priority wrong");
    irq_block_a: assert property (@(posedge clk) disable iff (rst)
        user_irq_blocked == (cpu_priority_level >= 4'h7))
        else $error("user interrupt block wrong");
    loop_flag_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> loop_busy_flag == $past(loop_active))
        else $error("loop flag mismatch");

endmodule // cpu_status_and_psv_mapping

// >>> verification/prog_memory_model.sv
// program memory model answering window fetches
`timescale 1ns/10ps
module prog_memory_model (
    input  wire logic        clk,
    input  wire logic        prog_rd,
    input  wire logic [22:0] prog_addr,
    output logic      [23:0] prog_word
);
    // upper byte is a nop pattern, so truncation to 16 bits is visible
    always @(posedge clk) begin
        if (prog_rd) begin
            prog_word <= {prog_addr[0] ? 8'hFF : 8'h00, prog_addr[15:0] ^ 16'hC35A};
        end else begin
            prog_word <= ~prog_word;
        end
    end
endmodule // prog_memory_model

// >>> verification/tb.sv
// self-checking bench for status word and program window
`timescale 1ns/10ps
module tb;
    import cpu_status_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  reg_addr, extra_cycles;
    logic [15:0] reg_wdata, reg_rdata, alu_a, alu_b, effective_address, window_data, exp_sr, sr;
    logic        reg_write, reg_read, alu_valid, alu_byte, alu_carry_in, loop_active, rd_req;
    logic        table_busy, insn_is_move, loop_edge, user_irq_blocked, prog_rd, window_hit;
    logic        window_fetch_second;
    logic [4:0]  upd;
    logic [23:0] prog_word;
    logic [3:0]  cpu_priority_level;
    logic [22:0] prog_addr;
    logic [7:0]  page;
    logic [7:0]  page_list [2] = '{8'hA4, 8'h5B};
    int          failures = 0;
    int          comparisons = 0;

    cpu_status_and_psv_mapping u_cpu_status_and_psv_mapping (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .alu_valid(alu_valid), .alu_byte(alu_byte),
        .alu_a(alu_a), .alu_b(alu_b), .alu_carry_in(alu_carry_in), .alu_update_half(upd[4]),
        .alu_update_neg(upd[3]), .alu_update_wrap(upd[2]), .alu_update_zero(upd[1]),
        .alu_update_carry(upd[0]), .loop_active(loop_active), .rd_req(rd_req),
        .effective_address(effective_address), .table_busy(table_busy), .insn_is_move(insn_is_move),
        .loop_edge(loop_edge), .prog_word(prog_word), .cpu_priority_level(cpu_priority_level),
        .user_irq_blocked(user_irq_blocked), .prog_rd(prog_rd), .prog_addr(prog_addr),
        .window_data(window_data), .window_hit(window_hit), .extra_cycles(extra_cycles),
        .window_fetch_second(window_fetch_second)
    );
    prog_memory_model u_prog_memory_model (
        .clk(clk), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_word(prog_word)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // ===========================================
    // register access and priority
    task automatic t_regs;
        rd(ADDR_STATUS, sr);
        check(sr, 16'h0000, "status after reset");
        check(cpu_priority_level, 4'h0, "level after reset");
        wr(ADDR_STATUS, 16'hFFFF);
        rd(ADDR_STATUS, sr);
        check(sr, 16'h01EF, "status all ones");
        check({cpu_priority_level, user_irq_blocked}, 5'h0F, "level seven");
        wr(ADDR_CONTROL, 16'h0008);
        repeat (2) @(posedge clk);
        #1 check({cpu_priority_level, user_irq_blocked}, 5'h1F, "level fifteen");
        wr(ADDR_CONTROL, 16'h0000);
        wr(ADDR_INTCTL, 16'h8000);
        wr(ADDR_STATUS, 16'h0000);
        rd(ADDR_STATUS, sr);
        check(sr, 16'h00E0, "priority locked");
        wr(ADDR_INTCTL, 16'h0000);
        wr(ADDR_STATUS, 16'h0000);
        rd(ADDR_STATUS, sr);
        check(sr, 16'h0000, "priority unlocked");
        check({cpu_priority_level, user_irq_blocked}, 5'h00, "level zero");
    endtask

    // ===========================================
    // repeat loop indicator
    task automatic t_loop;
        @(posedge clk);
        loop_active <= 1'b1;
        rd(ADDR_STATUS, sr);
        check(sr, 16'h0010, "loop busy set");
        @(posedge clk);
        loop_active <= 1'b0;
        rd(ADDR_STATUS, sr);
        check(sr, 16'h0000, "loop busy clear");
    endtask

    // ===========================================
    // alu flag updates
    task automatic alu(input logic byt, input logic [15:0] a, input logic [15:0] b, input logic ci,
                       input logic [4:0] u);
        logic [16:0] s;
        logic [8:0]  h;
        int          m;
        m = byt ? 7 : 15;
        s = byt ? 17'(a[7:0]) + 17'(b[7:0]) + 17'(ci) : 17'(a) + 17'(b) + 17'(ci);
        h = byt ? 9'(a[3:0]) + 9'(b[3:0]) + 9'(ci) : 9'(a[7:0]) + 9'(b[7:0]) + 9'(ci);
        if (u[4]) exp_sr[8] = byt ? h[4] : h[8];
        if (u[3]) exp_sr[3] = s[m];
        if (u[2]) exp_sr[2] = (a[m] == b[m]) && (s[m] != a[m]);
        if (u[1]) exp_sr[1] = byt ? (s[7:0] == 8'h00) : (s[15:0] == 16'h0000);
        if (u[0]) exp_sr[0] = s[m+1];
        @(posedge clk);
        alu_valid    <= 1'b1;
        alu_byte     <= byt;
        alu_a        <= a;
        alu_b        <= b;
        alu_carry_in <= ci;
        upd          <= u;
        @(posedge clk);
        alu_valid <= 1'b0;
        rd(ADDR_STATUS, sr);
        check(sr, exp_sr, "status flags");
    endtask

    task automatic t_alu;
        exp_sr = 16'h0000;
        alu(1'b0, 16'hFFFF, 16'h0001, 1'b0, 5'h1F);
        alu(1'b1, 16'h007F, 16'h0001, 1'b0, 5'h1F);
        alu(1'b0, 16'h1234, 16'h0001, 1'b1, 5'h00);
        alu(1'b1, 16'h0F80, 16'h0080, 1'b0, 5'h1F);
        alu(1'b0, 16'h8000, 16'h8000, 1'b0, 5'h1D);
        alu(1'b0, 16'h1234, 16'h0001, 1'b0, 5'h02);
    endtask

    // ===========================================
    // program window reads
    task automatic win(input logic [15:0] ea, input logic mv, input logic edg, input logic tbz,
                       input logic hit, input logic [1:0] ex);
        logic [22:0] pa;
        pa = {page, ea[14:0]};
        @(posedge clk);
        rd_req            <= 1'b1;
        effective_address <= ea;
        insn_is_move      <= mv;
        loop_edge         <= edg;
        table_busy        <= tbz;
        @(posedge clk);
        rd_req     <= 1'b0;
        table_busy <= 1'b0;
        #1 check({prog_rd, window_hit}, {hit, hit}, "window hit");
        check(extra_cycles, hit ? ex : EXTRA_NONE, "extra cycles");
        if (hit) begin
            check(prog_addr, pa, "program address");
            @(posedge clk);
            #1 check(window_fetch_second, 1'b1, "second fetch");
            @(posedge clk);
            #1 check(window_data, pa[15:0] ^ 16'hC35A, "window data");
        end
        @(posedge clk);
    endtask

    task automatic t_window;
        wr(ADDR_CONTROL, 16'h0004);
        foreach (page_list[i]) begin
            page = page_list[i];
            wr(ADDR_PAGE, {8'h00, page});
            win(16'h8123, 1'b1, 1'b0, 1'b0, 1'b1, EXTRA_MOVE);
        end
        win(16'hFFFE, 1'b0, 1'b0, 1'b0, 1'b1, EXTRA_OTHER);
        win(16'h0123, 1'b1, 1'b0, 1'b0, 1'b0, EXTRA_NONE);
        win(16'h8123, 1'b1, 1'b0, 1'b1, 1'b0, EXTRA_NONE);
        loop_active <= 1'b1;
        win(16'h9000, 1'b1, 1'b1, 1'b0, 1'b1, EXTRA_OTHER);
        win(16'h9002, 1'b0, 1'b0, 1'b0, 1'b1, EXTRA_NONE);
        loop_active <= 1'b0;
        wr(ADDR_CONTROL, 16'h0000);
        win(16'h8123, 1'b1, 1'b0, 1'b0, 1'b0, EXTRA_NONE);
    endtask

    task automatic conclude;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        {reg_addr, reg_wdata, reg_write, reg_read, alu_valid, alu_byte, alu_a, alu_b} = '0;
        {alu_carry_in, upd, loop_active, rd_req, effective_address} = '0;
        {table_busy, insn_is_move, loop_edge, page} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_loop;
        t_alu;
        t_window;
        conclude;
    end

    initial begin
        #100us;
        failures++;
        conclude;
    end
endmodule // tb
